/* File: logic/flash_cmd_map.svh */
// Offsets, field positions, reset values and limits of the flash command block
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
// Register byte offsets
`define OFS_STATUS      8'h00
`define OFS_INDEX       8'h04
`define OFS_PARAM       8'h08
`define OFS_SECURITY    8'h0c
`define OFS_PROTECT     8'h10
`define OFS_MODE        8'h14
// Status field positions
`define BIT_COMMAND_COMPLETE_FLAG        7
`define BIT_ACCESS_ERROR_FLAG      5
`define BIT_PROTECTION_VIOLATION_FLAG      4
`define BIT_VERR        1
`define BIT_UNCORR      0
// Security field positions
`define BIT_SECURED     8
// Command codes
`define CMD_ERASE_BLOCK  8'h09
`define CMD_ERASE_SECTOR 8'h0a
`define CMD_UNSECURE     8'h0b
`define CMD_BACKDOOR     8'h0c
// Expected parameter index per command
`define IDX_ERASE       3'h1
`define IDX_UNSECURE    3'h0
`define IDX_BACKDOOR    3'h4
`define KEY_ENABLE_FIELD_ENABLED   2'h2
// Memory layout
`define PF_BASE         24'hfe0000
`define PF_SIZE         24'h020000
`define EE_BASE         24'h100000
`define EE_SIZE         24'h001000
`define KEY_BASE        24'hfffe00
`define SECTOR_SIZE     24'h000200
`define REGION_SHIFT    14
// Reset values
`define RST_KEY_ENABLE_FIELD       2'h0
`define RST_PROTECT     9'h000
`define RST_MODE        4'hf
`endif

/* File: logic/flash_cmd_pkg.sv */
// Types shared by the flash command block and its environment
`default_nettype none
package flash_cmd_pkg;
  // Sequencer states, Gray along idle-check-erase-done
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_CHECK  = 3'h1,
    ST_ERASE  = 3'h3,
    ST_DONE   = 3'h2,
    ST_KEYRD  = 3'h7,
    ST_KEYCMP = 3'h5
  } state_type;
  // Operations asked of the flash array
  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_BLOCK  = 2'h1,
    OP_SECTOR = 2'h2,
    OP_ALL    = 2'h3
  } flash_op_type;
  // Erase request toward the array
  typedef struct packed {
    logic         start;
    flash_op_type op;
    logic [23:0]  addr;
  } flash_req_type;
  // Erase and verify result from the array
  typedef struct packed {
    logic done;
    logic verify_err;
    logic uncorr;
  } flash_rsp_type;
endpackage
`default_nettype wire

/* File: logic/flash_cmd.sv */
// Flash erase and security command sequencer with AHB-Lite registers
// Function
// - Block erase: code 09, address in words 0-1
// - Block erase erases, verifies, then completes
// - Block erase index/alignment errors raise access error
// - Protected block region raises protection violation
// - Verify errors set verify status bits
// - Sector erase code 0A, any 8-byte aligned address inside
// - Sector erase index/alignment errors raise access error
// - Protected sector raises protection violation
// - Sector erase erases, verifies, then completes
// - Unsecure code 0B, index must be 000
// - Unsecure erases all, verifies, releases security
// - Unsecure verify failure keeps security
// - Any protection fails unsecure with violation
// - Backdoor code 0C, four keys, index 100
// - Key enable must be 10 first
// - Keys compared in order from key base
// - Mismatch locks backdoor until reset
// - Backdoor completes, never sets violation/verify bits
// - Command not permitted in mode: access error
// - Invalid erase address raises access error
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`include "flash_cmd_map.svh"
`default_nettype none
module flash_cmd #(
  parameter logic [23:0] PF_BASE  = `PF_BASE,
  parameter logic [23:0] PF_SIZE  = `PF_SIZE,
  parameter logic [23:0] EE_BASE  = `EE_BASE,
  parameter logic [23:0] EE_SIZE  = `EE_SIZE,
  parameter logic [23:0] SEC_SIZE = `SECTOR_SIZE
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST,
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic [31:0]                 HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  output flash_cmd_pkg::flash_req_type FLASH_REQ,
  input  wire flash_cmd_pkg::flash_rsp_type FLASH_RSP,
  output logic [23:0]                 KEY_ADDR,
  input  wire logic [15:0]            KEY_DATA
);
  import flash_cmd_pkg::*;
  // Overview of the block
  // The host loads index and parameter words, then writes one to the
  // complete flag to launch; the sequencer checks the launch, drives the
  // array or walks the stored key, and raises completion at the end.
  // Only one command is in flight; the bus stays readable throughout,
  // but every register write is dropped until completion returns.

  // Bus data phase bookkeeping
  logic        wr_q;        // Write data phase pending
  logic        rd_q;        // Read wait cycle pending
  logic [7:0]  addr_q;      // Latched register offset
  logic [31:0] rdata_q;     // Registered read data
  // Software visible state
  logic        command_complete_flag_q;      // Command complete flag
  logic        access_error_flag_q;    // Access error flag
  logic        protection_violation_flag_q;    // Protection violation flag
  logic        verr_q;      // Verify error bit
  logic        uncorr_q;    // Uncorrectable verify bit
  logic [2:0]  index_q;     // Parameter index
  logic [15:0] words_q [6]; // Command parameter words
  logic [1:0]  key_enable_field_q;     // Key enable field
  logic        secured_q;   // Security state
  logic [8:0]  prot_q;      // Region protection map
  logic [3:0]  mode_q;      // Per-command permission
  logic        key_fail_q;  // Backdoor locked until reset
  // Sequencer
  state_type     state_q;
  flash_req_type req_q;
  logic [1:0]    key_idx_q;
  logic [23:0]   key_addr_q;

  // Command fields are decoded straight from the parameter words.
  // They only matter in the check state; the words cannot change then,
  // because writes are locked while the command runs, so no copy is
  // taken at launch. That saves a 24-bit register per command.
  // Decoded command fields
  logic [7:0]  cmd;
  logic [23:0] gaddr;
  logic        in_pf;
  logic        in_ee;
  logic [23:0] pf_off;
  logic [2:0]  region;
  logic        acc_err;
  logic        prot_err;
  logic        launch;
  logic        bus_act;

  assign cmd    = words_q[0][15:8];
  assign gaddr  = {words_q[0][7:0], words_q[1]};
  assign in_pf  = (gaddr >= PF_BASE) && ((gaddr - PF_BASE) < PF_SIZE);
  assign in_ee  = (gaddr >= EE_BASE) && ((gaddr - EE_BASE) < EE_SIZE);
  assign pf_off = gaddr - PF_BASE;
  assign region = pf_off[`REGION_SHIFT+2:`REGION_SHIFT];

  // Access errors win over protection: only one flag per launch.
  // Protection is irrelevant to the backdoor command, which never
  // reports a violation; its prot_err stays low.
  // Region size is a power of two, so the region number is a slice
  // of the offset into program flash and needs no divider.
  // Launch-time checks per command
  always_comb begin
    acc_err  = 1'b0;
    prot_err = 1'b0;
    case (cmd)
      `CMD_ERASE_BLOCK: begin
        acc_err = (index_q != `IDX_ERASE) || !mode_q[0]
                || !(in_pf || in_ee)
                || (in_pf && (gaddr[2:0] != 3'h0))
                || (in_ee && gaddr[0]);
        prot_err = in_pf ? (|prot_q[7:0]) : prot_q[8];
      end
      `CMD_ERASE_SECTOR: begin
        acc_err = (index_q != `IDX_ERASE) || !mode_q[1]
                || !in_pf
                || (gaddr[2:0] != 3'h0);
        prot_err = prot_q[region];
      end
      `CMD_UNSECURE: begin
        acc_err  = (index_q != `IDX_UNSECURE) || !mode_q[2];
        prot_err = |prot_q;
      end
      `CMD_BACKDOOR: begin
        // Enable and lock are tested before any key is read
        acc_err = (index_q != `IDX_BACKDOOR) || !mode_q[3]
                || (key_enable_field_q != `KEY_ENABLE_FIELD_ENABLED)
                || key_fail_q;
      end
      default: begin
        // Codes outside this block are refused
        acc_err = 1'b1;
      end
    endcase
  end

  // A launch is a status write with the complete bit set while idle.
  // Writing the bit while a command runs does nothing; the host polls
  // the status word instead.
  // Error flags are not required clear for a launch.
  // Bus transfer accepted whenever selected, ready and active, command running or not
  assign bus_act = HSEL && HREADY && HTRANS[1];
  assign launch  = wr_q && (addr_q == `OFS_STATUS) && command_complete_flag_q && HWDATA[`BIT_COMMAND_COMPLETE_FLAG];

  // The address phase is held in flops so the data phase can find
  // the register one cycle later. Only the low byte is decoded, so
  // the register window aliases across the rest of the slave's range.
  // Width and burst fields are ignored: single word transfers only.
  // AHB address phase capture
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= bus_act && HWRITE;
      rd_q <= bus_act && !HWRITE;
      if (bus_act) begin
        addr_q <= HADDR[7:0];
      end
    end
  end

  // Reads cost one wait state; in exchange read data leaves a flop
  // and needs no multiplexer in the data-phase path.
  // Read data, one wait cycle so it comes from a flop
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_q <= 32'h0;
    end else if (bus_act && !HWRITE) begin
      if (HADDR[7:0] == `OFS_STATUS) begin
        rdata_q <= {24'h0, command_complete_flag_q, 1'b0, access_error_flag_q, protection_violation_flag_q, 2'h0, verr_q, uncorr_q};
      end else if (HADDR[7:0] == `OFS_INDEX) begin
        rdata_q <= {29'h0, index_q};
      end else if (HADDR[7:0] == `OFS_PARAM) begin
        rdata_q <= (index_q < 3'h6) ? {16'h0, words_q[index_q]} : 32'h0;
      end else if (HADDR[7:0] == `OFS_SECURITY) begin
        rdata_q <= {23'h0, secured_q, 6'h0, key_enable_field_q};
      end else if (HADDR[7:0] == `OFS_PROTECT) begin
        rdata_q <= {23'h0, prot_q};
      end else if (HADDR[7:0] == `OFS_MODE) begin
        rdata_q <= {28'h0, mode_q};
      end else begin
        // Unmapped reads return zero
        rdata_q <= 32'h0;
      end
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = !rd_q;
  assign HRESP     = 1'b0;

  // Writes land at the end of the data phase. Any write while a
  // command runs is dropped without an error response, so a
  // misbehaving host only loses its data and cannot upset the array.
  // Parameter words beyond the sixth are not stored.
  // Configuration writes, locked out while a command runs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      index_q <= 3'h0;
      key_enable_field_q <= `RST_KEY_ENABLE_FIELD;
      prot_q  <= `RST_PROTECT;
      mode_q  <= `RST_MODE;
      for (int i = 0; i < 6; i++) begin
        words_q[i] <= 16'h0;
      end
    end else if (wr_q && command_complete_flag_q) begin
      if (addr_q == `OFS_INDEX) begin
        index_q <= HWDATA[2:0];
      end else if (addr_q == `OFS_PARAM) begin
        if (index_q < 3'h6) begin
          words_q[index_q] <= HWDATA[15:0];
        end
      end else if (addr_q == `OFS_SECURITY) begin
        key_enable_field_q <= HWDATA[1:0];
      end else if (addr_q == `OFS_PROTECT) begin
        prot_q <= HWDATA[8:0];
      end else if (addr_q == `OFS_MODE) begin
        mode_q <= HWDATA[3:0];
      end
    end
  end

  // Path: idle, check, then erase or key walk (straight to done if the check fails), then done, then idle.
  // The done state lasts one cycle so completion always rises one
  // edge after the last step, whichever branch was taken.
  // Key words are read two bytes apart; one read cycle is spent per
  // key because stored data stands only one cycle after the address.
  // Command sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q    <= ST_IDLE;
      req_q      <= '0;
      key_idx_q  <= 2'h0;
      key_addr_q <= `KEY_BASE;
    end else begin
      req_q.start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (acc_err || (prot_err && (cmd != `CMD_BACKDOOR))) begin
            state_q <= ST_DONE;
          end else if (cmd == `CMD_BACKDOOR) begin
            key_idx_q  <= 2'h0;
            key_addr_q <= `KEY_BASE;
            state_q    <= ST_KEYRD;
          end else begin
            req_q.start <= 1'b1;
            state_q     <= ST_ERASE;
            if (cmd == `CMD_ERASE_BLOCK) begin
              req_q.op   <= OP_BLOCK;
              req_q.addr <= gaddr;
            end else if (cmd == `CMD_ERASE_SECTOR) begin
              // Round down to the sector holding the address
              req_q.op   <= OP_SECTOR;
              req_q.addr <= gaddr & ~(SEC_SIZE - 24'h1);
            end else begin
              req_q.op   <= OP_ALL;
              req_q.addr <= 24'h0;
            end
          end
        end
        ST_ERASE: begin
          // Completion waits for erase and verify both
          if (FLASH_RSP.done) begin
            state_q <= ST_DONE;
          end
        end
        ST_KEYRD: begin
          // Array data stands one cycle after the address
          state_q <= ST_KEYCMP;
        end
        ST_KEYCMP: begin
          if (KEY_DATA != words_q[3'(key_idx_q) + 3'h1]) begin
            state_q <= ST_DONE;
          end else if (key_idx_q == 2'h3) begin
            state_q <= ST_DONE;
          end else begin
            key_idx_q  <= key_idx_q + 2'h1;
            key_addr_q <= key_addr_q + 24'h2;
            state_q    <= ST_KEYRD;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign FLASH_REQ = req_q;
  assign KEY_ADDR  = key_addr_q;

  // Launch clears the complete flag and the verify bits; error flags persist until the
  // host clears them by writing ones. Verify bits are loaded together
  // with the array's done pulse, so they never show a stale mix.
  // A clear can only come while idle, so it never meets a set here.
  // Status flags: clears first, so a hardware set in the same cycle wins
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      command_complete_flag_q   <= 1'b1;
      access_error_flag_q <= 1'b0;
      protection_violation_flag_q <= 1'b0;
      verr_q   <= 1'b0;
      uncorr_q <= 1'b0;
    end else begin
      if (wr_q && command_complete_flag_q && (addr_q == `OFS_STATUS)) begin
        if (HWDATA[`BIT_ACCESS_ERROR_FLAG]) begin
          access_error_flag_q <= 1'b0;
        end
        if (HWDATA[`BIT_PROTECTION_VIOLATION_FLAG]) begin
          protection_violation_flag_q <= 1'b0;
        end
      end
      if (launch) begin
        command_complete_flag_q   <= 1'b0;
        verr_q   <= 1'b0;
        uncorr_q <= 1'b0;
      end
      if (state_q == ST_CHECK) begin
        if (acc_err) begin
          access_error_flag_q <= 1'b1;
        end else if (prot_err && (cmd != `CMD_BACKDOOR)) begin
          protection_violation_flag_q <= 1'b1;
        end
      end
      if ((state_q == ST_ERASE) && FLASH_RSP.done) begin
        verr_q   <= FLASH_RSP.verify_err;
        uncorr_q <= FLASH_RSP.uncorr;
      end
      if ((state_q == ST_KEYCMP) && (KEY_DATA != words_q[3'(key_idx_q) + 3'h1])) begin
        access_error_flag_q <= 1'b1;
      end
      if (state_q == ST_DONE) begin
        command_complete_flag_q <= 1'b1;
      end
    end
  end

  // Security is released either by a clean full erase or by a full key
  // match. A single mismatched key locks the backdoor until reset,
  // which stops a host from guessing the key one word at a time.
  // An uncorrectable report alone does not keep the part secured.
  // Security state and backdoor lock
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      secured_q  <= 1'b1;
      key_fail_q <= 1'b0;
    end else begin
      if ((state_q == ST_ERASE) && FLASH_RSP.done && (req_q.op == OP_ALL)
          && !FLASH_RSP.verify_err) begin
        secured_q <= 1'b0;
      end
      if (state_q == ST_KEYCMP) begin
        if (KEY_DATA != words_q[3'(key_idx_q) + 3'h1]) begin
          key_fail_q <= 1'b1;
        end else if (key_idx_q == 2'h3) begin
          secured_q <= 1'b0;
        end
      end
    end
  end
endmodule // flash_cmd
`default_nettype wire

/* File: testbench/flash_cmd_assertions.sv */
// Checker of bus timing and erase requests of the flash command block
`default_nettype none
module flash_cmd_assertions #(
  parameter logic [23:0] SEC_SIZE = 24'h000200
) (
  input wire logic                         CORE_CLK,
  input wire logic                         RST,
  input wire logic                         HSEL,
  input wire logic [1:0]                   HTRANS,
  input wire logic                         HWRITE,
  input wire logic                         HREADY,
  input wire logic                         HREADYOUT,
  input wire logic                         HRESP,
  input wire flash_cmd_pkg::flash_req_type FLASH_REQ,
  input wire logic [23:0]                  KEY_ADDR
);
  import flash_cmd_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Accepted read and its single wait state
  sequence rd_acc; HSEL && HREADY && HTRANS[1] && !HWRITE; endsequence
  sequence rd_wait; !HREADYOUT ##1 HREADYOUT; endsequence
  logic        go;   // Erase launch pulse
  logic [23:0] ra;   // Erase address
  logic        pf;   // Address inside program flash
  logic        ee;   // Address inside data eeprom
  assign go = FLASH_REQ.start;
  assign ra = FLASH_REQ.addr;
  assign pf = ra >= 24'hfe0000;
  assign ee = ra >= 24'h100000 && ra < 24'h101000;
  chk_resp_okay: assert property (HRESP == 1'b0) else $error("error response");
  chk_read_wait: assert property (rd_acc |=> rd_wait) else $error("read wait wrong");
  chk_write_zero: assert property (HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
    else $error("write waited");
  chk_start_pulse: assert property (go |=> !go) else $error("start too long");
  chk_req_stands: assert property (!go |-> $stable(ra) && $stable(FLASH_REQ.op))
    else $error("request moved");
  chk_sector_round: assert property (go && FLASH_REQ.op == OP_SECTOR |-> pf && ra % SEC_SIZE == 24'h0)
    else $error("sector address");
  chk_block_align: assert property (go && FLASH_REQ.op == OP_BLOCK |->
    (pf && ra[2:0] == 3'h0) || (ee && !ra[0])) else $error("block address");
  chk_key_window: assert property (KEY_ADDR >= 24'hfffe00 && KEY_ADDR <= 24'hfffe06 && !KEY_ADDR[0])
    else $error("key address");
endmodule // flash_cmd_assertions
bind flash_cmd flash_cmd_assertions #(.SEC_SIZE(SEC_SIZE)) chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .FLASH_REQ(FLASH_REQ), .KEY_ADDR(KEY_ADDR));
`default_nettype wire

/* File: testbench/tb_flash_cmd.sv */
// Self-checking bench of the flash command block
`default_nettype none
module tb_flash_cmd;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_cmd_pkg::*;
  typedef struct packed { logic [31:0] m; logic [31:0] v; } note_type;
  typedef struct packed {
    logic [7:0] c; logic [23:0] a; logic [3:0] ix; logic [11:0] pr;
    logic [3:0] md; logic [7:0] st; logic [3:0] op;
  } row_type;
  logic          CORE_CLK = 1'h0, RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0;
  logic [31:0]   HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0]    HTRANS = 2'h0;
  logic          HREADYOUT, HRESP, verr = 1'h0, unc = 1'h0, rd_ph = 1'h0;
  flash_req_type FLASH_REQ;
  flash_rsp_type FLASH_RSP = 3'h0;
  logic [23:0]   KEY_ADDR, a;
  logic [15:0]   KEY_DATA = 16'h0, pw[5], key[4];
  logic [31:0]   got;
  note_type      rd_q[$], rq_q[$], n;
  row_type       r;
  int            bad_count = 0, cmp_count = 0, seed = 32'hc6c014c9, cnt = 0;
  // Launch checks: faults, modes, protection
  row_type tbl[18] = '{
    64'h09_100002_1_000_f_80_1, 64'h09_fe0008_2_000_f_a0_0, 64'h09_fe0004_1_000_f_a0_0,
    64'h09_100001_1_000_f_a0_0, 64'h09_200000_1_000_f_a0_0, 64'h0a_200000_1_000_f_a0_0,
    64'h0a_fe0101_1_000_f_a0_0, 64'h0a_fe0010_0_000_f_a0_0, 64'h09_fe0000_1_080_f_90_0,
    64'h0a_ffc000_1_080_f_90_0, 64'h0a_fe4010_1_080_f_80_2, 64'h09_100000_1_100_f_90_0,
    64'h09_fe0000_1_000_e_a0_0, 64'h0a_fe0000_1_000_d_a0_0, 64'h0b_000000_0_000_b_a0_0,
    64'h0b_000000_1_000_f_a0_0, 64'h0b_000000_0_100_f_90_0, 64'h0c_000000_4_000_f_a0_0};
  flash_cmd dut (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FLASH_REQ(FLASH_REQ), .FLASH_RSP(FLASH_RSP),
    .KEY_ADDR(KEY_ADDR), .KEY_DATA(KEY_DATA));
  // Free running clock
  initial begin
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Monitor: reads and erase requests against the oldest note
  always @(posedge CORE_CLK) begin
    if (rd_ph && HREADYOUT) begin
      rd_ph = 1'h0;
      n = rd_q.pop_front();
      if (n.m != 32'h0) chk(HRDATA & n.m, n.v);
    end
    if (HSEL && HREADYOUT && HTRANS[1] && !HWRITE) rd_ph = 1'h1;
    if (FLASH_REQ.start) begin
      n = rq_q.size() ? rq_q.pop_front() : 64'h1;   // Unasked erase fails
      chk(32'(FLASH_REQ[25:0]) & n.m, n.v);
    end
  end
  // Flash array with a random erase time; key store with junk outside it
  always @(posedge CORE_CLK) begin
    FLASH_RSP <= 3'h0;
    if (FLASH_REQ.start) cnt = 2 + ($random(seed) & 7);
    else if (cnt > 1) cnt--;
    else if (cnt == 1) begin
      cnt = 0;
      FLASH_RSP <= {1'h1, verr, unc};
    end
    KEY_DATA <= KEY_ADDR[23:3] == 21'h1fffc0 ? key[KEY_ADDR[2:1]] : 16'($random(seed));
  end
  // One single transfer; hold until ready is seen high
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    HSEL <= 1'h1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= {24'h0, ad};
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'h1);
    HSEL <= 1'h0; HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'h1);
    got = HRDATA;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'h1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] v);
    rd_q.push_back('{m, v & m});
    xfer(1'h0, ad, 32'h0);
  endtask
  // Load words, launch, wait for completion, check and clear flags
  task automatic go(input logic [2:0] ix, input logic [7:0] st);
    for (int k = 0; k < 5; k++) begin
      wr(8'h04, 32'(k));
      wr(8'h08, {16'h0, pw[k]});
    end
    wr(8'h04, {29'h0, ix});
    wr(8'h00, 32'h80);
    got = 32'h0;
    // Only status reads until completion: no writes while running
    for (int k = 0; k < 300 && !got[7]; k++) rd(8'h00, 32'h0, 32'h0);
    rd(8'h00, 32'hb3, {24'h0, st});
    wr(8'h00, 32'h30);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge CORE_CLK);
    bad_count++;
    print_verdict();
  end
  initial begin
    for (int k = 0; k < 4; k++) key[k] = 16'($random(seed));
    repeat (8) @(posedge CORE_CLK);
    RST <= 1'h0;
    @(posedge CORE_CLK);
    rd(8'h00, 32'hff, 32'h80);
    rd(8'h0c, 32'h103, 32'h100);
    rd(8'h14, 32'hf, 32'hf);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'hffffffff, 32'h0);
    $display("test reset values done");
    // Good erases at random places, every verify outcome
    for (int k = 0; k < 8; k++) begin
      a = {7'h7f, k[0], 16'($random(seed))} & 24'hfffff8;
      {verr, unc} = k[1:0];
      pw = '{{k[2] ? 8'h0a : 8'h09, a[23:16]}, a[15:0], 16'h0, 16'h0, 16'h0};
      rq_q.push_back('{32'h3ffffff, {6'h0, k[2] ? OP_SECTOR : OP_BLOCK, k[2] ? a & 24'hfffe00 : a}});
      go(3'h1, {6'h20, k[1:0]});
    end
    {verr, unc} = 2'h0;
    $display("test erase done");
    foreach (tbl[i]) begin
      r = tbl[i];
      wr(8'h10, {20'h0, r.pr});
      wr(8'h14, {28'h0, r.md});
      pw = '{{r.c, r.a[23:16]}, r.a[15:0], 16'h0, 16'h0, 16'h0};
      // Block erase keeps the address, sector erase rounds it to its sector
      if (r.op != 4'h0) rq_q.push_back('{32'h3ffffff, {6'h0, r.op[1:0],
        (r.op == 4'h2) ? (r.a & 24'hfffe00) : r.a}});
      go(r.ix[2:0], r.st);
    end
    wr(8'h10, 32'h0);
    wr(8'h14, 32'hf);
    $display("test launch checks done");
    // Right key, then after a reset a wrong key locks out the right one
    for (int k = 0; k < 3; k++) begin
      pw = '{16'h0c00, key[0], key[1], key[2], key[3] ^ 16'(k == 1)};
      wr(8'h0c, 32'h2);
      go(3'h4, k ? 8'ha0 : 8'h80);
      rd(8'h0c, 32'h103, k ? 32'h102 : 32'h2);
      if (k == 0) begin
        RST <= 1'h1;
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'h0;
        @(posedge CORE_CLK);
      end
    end
    $display("test backdoor done");
    // Unsecure: failed verify keeps security, clean verify releases it
    for (int k = 0; k < 2; k++) begin
      pw = '{16'h0b00, 16'h0, 16'h0, 16'h0, 16'h0};
      verr = !k;
      rq_q.push_back('{32'h3000000, 32'h3000000});
      go(3'h0, k ? 8'h80 : 8'h82);
      rd(8'h0c, 32'h100, k ? 32'h0 : 32'h100);
    end
    $display("test unsecure done");
    print_verdict();
  end
endmodule // tb_flash_cmd
`default_nettype wire
